// ==== rtl/sfrp_pkg.sv ====
// constants and types shared by the serial flash read/program command logic
// assumes a single command engine top, sfrp_core, that imports this package
package sfrp_pkg;

  // ****************************************
  // opcodes
  // ****************************************
  localparam logic [7:0] OP_FAST_RD   = 8'h0B;
  localparam logic [7:0] OP_DUAL_RD   = 8'h3B;
  localparam logic [7:0] OP_LOCK_RD   = 8'hE8;
  localparam logic [7:0] OP_OTP_RD    = 8'h4B;
  localparam logic [7:0] OP_PROG      = 8'h02;
  localparam logic [7:0] OP_DUAL_PROG = 8'hA2;
  localparam logic [7:0] OP_WR_EN     = 8'h06;
  localparam logic [7:0] OP_WR_DIS    = 8'h04;
  localparam logic [7:0] OP_LOCK_WR   = 8'hE5;

  // ****************************************
  // frame layout
  // ****************************************
  localparam logic [4:0] CMD_BITS   = 5'h08;
  localparam logic [4:0] ADDR_BITS  = 5'h18;
  localparam logic [4:0] DUMMY_BITS = 5'h08;
  localparam logic [4:0] BYTE_BITS  = 5'h08;

  // ****************************************
  // storage layout and reset values
  // ****************************************
  localparam int         MEM_AW_DEF   = 23;
  localparam int         SECT_AW_DEF  = 16;
  localparam int         PAGE_AW      = 8;
  localparam logic [6:0] OTP_LAST_IDX = 7'h40;
  localparam logic [7:0] ERASED_BYTE  = 8'hFF;
  localparam int         LOCK_WL_BIT  = 0;
  localparam int         LOCK_FRZ_BIT = 1;
  localparam logic       LOCK_RESET   = 1'b0;
  localparam logic       WEL_RESET    = 1'b0;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int PROG_TIME_NS  = 800000;
  localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [5:0] {
    L_CMD    = 6'h01,
    L_ADDR   = 6'h02,
    L_DUMMY  = 6'h04,
    L_RDATA  = 6'h08,
    L_PDATA  = 6'h10,
    L_IGNORE = 6'h20
  } sfrp_lst_t;

  typedef enum logic [9:0] {
    K_NONE   = 10'h001,
    K_FAST   = 10'h002,
    K_DUAL   = 10'h004,
    K_LOCK   = 10'h008,
    K_OTP    = 10'h010,
    K_PROG   = 10'h020,
    K_DPROG  = 10'h040,
    K_WREN   = 10'h080,
    K_WRDI   = 10'h100,
    K_LOCKWR = 10'h200
  } sfrp_kind_t;

  typedef enum logic [2:0] {
    C_IDLE  = 3'h1,
    C_WRITE = 3'h2,
    C_WAIT  = 3'h4
  } sfrp_cst_t;

endpackage

// ==== rtl/sfrp_core.sv ====
// serial flash command engine: fast, dual, lock and one-time reads, single and dual page program
// assumes a host controller driving select, serial clock and data lines; pins resolved by the host model
//
// Notes on behaviour
// RQ1: fast read takes 24 address bits, one dummy byte, then data on line 1.
// RQ2: fast read address advances per byte and wraps to zero past the top.
// RQ3: select high ends any read; output drive stops at once.
// RQ4: reads and every other command are ignored while a self-timed cycle runs.
// RQ5: dual read shares the fast read header, then outputs two bits per clock.
// RQ6: dual read address advances per byte and wraps to zero past the top.
// RQ7: lock read takes 24 address bits, no dummy, returns that sector's lock byte.
// RQ8: a set freeze bit blocks lock changes until power-up; clear allows both.
// RQ9: a set sector write lock blocks programming of that sector.
// RQ10: one-time area read takes address and dummy, outputs bytes, address increments.
// RQ11: one-time area read never wraps; the 65th byte repeats until select rises.
// RQ12: program accepted only when write enable latched beforehand.
// RQ13: host sends opcode, three address bytes, data bytes with select held low.
// RQ14: program data past the page end wraps to offset zero of that page.
// RQ15: only the last 256 bytes are kept; unsent bytes stay untouched.
// RQ16: program runs only if select rises on a byte boundary.
// RQ17: select rise starts the timed cycle; busy held, write latch cleared.
// RQ18: programming only turns ones into zeros.
// RQ19: program refused when its page lies in the protected region.
// RQ20: dual program follows program rules, data two bits per clock.
// RQ21: host should gather consecutive bytes into one program sequence.
// RQ22: lock byte bit0 is write lock, bit1 freeze, upper bits zero.
// RQ23: bytes travel msb first; line 1 carries the higher bit of a pair.
// RQ24: opcode, address and dummy bits arrive on line 0, one per rising edge.
`timescale 1ns/1ns
module sfrp_core #(
  parameter int MEM_AW      = sfrp_pkg::MEM_AW_DEF,
  parameter int SECT_AW     = sfrp_pkg::SECT_AW_DEF,
  parameter int PROG_CYCLES = sfrp_pkg::PROG_CYCLES
) (
  // system clock and reset
  input  wire logic       I_CLK,
  input  wire logic       I_RSTN,
  // serial link
  input  wire logic       I_SCLK,
  input  wire logic       I_SELECT_N,
  input  wire logic       I_IO_LINE_0,
  input  wire logic       I_IO_LINE_1,
  output logic            O_IO_LINE_0,
  output logic            O_IO_LINE_0_OE_N,
  output logic            O_IO_LINE_1,
  output logic            O_IO_LINE_1_OE_N,
  // protection level straps
  input  wire logic       I_PROTECT_LEVEL_BIT2,
  input  wire logic       I_PROTECT_LEVEL_BIT1,
  input  wire logic       I_PROTECT_LEVEL_BIT0,
  // status
  output logic            O_BUSY_FLAG,
  output logic            O_WRITE_LATCH_FLAG
);
  import sfrp_pkg::*;

  localparam int NSECT     = 1 << (MEM_AW - SECT_AW);
  localparam int MEM_BYTES = 1 << MEM_AW;
  localparam int PAGE_N    = 1 << PAGE_AW;
  localparam int PG_W      = MEM_AW - PAGE_AW;
  localparam int TMR_W     = $clog2(PROG_CYCLES + 1);

  // ****************************************
  // storage
  // ****************************************
  logic [7:0]         mem       [0:MEM_BYTES-1];
  logic [7:0]         pbuf      [0:PAGE_N-1];
  logic [PAGE_N-1:0]  pmask_r;
  logic [NSECT-1:0]   lock_wl_r;
  logic [NSECT-1:0]   lock_frz_r;

  // flash array starts erased
  initial begin
    for (int i = 0; i < MEM_BYTES; i++) begin
      mem[i] = ERASED_BYTE;
    end
  end

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic sfrp_kind_t kind_of(input logic [7:0] op);
    case (op)
      OP_FAST_RD:   kind_of = K_FAST;
      OP_DUAL_RD:   kind_of = K_DUAL;
      OP_LOCK_RD:   kind_of = K_LOCK;
      OP_OTP_RD:    kind_of = K_OTP;
      OP_PROG:      kind_of = K_PROG;
      OP_DUAL_PROG: kind_of = K_DPROG;
      OP_WR_EN:     kind_of = K_WREN;
      OP_WR_DIS:    kind_of = K_WRDI;
      OP_LOCK_WR:   kind_of = K_LOCKWR;
      default:      kind_of = K_NONE;
    endcase
  endfunction

  function automatic logic [MEM_AW-SECT_AW-1:0] sect_of(input logic [MEM_AW-1:0] a);
    sect_of = a[MEM_AW-1:SECT_AW];
  endfunction

  // top-down protection: level n covers the top NSECT >> (7-n) sectors, 0 covers none, 7 covers all
  function automatic logic prot_hit(input logic [MEM_AW-SECT_AW-1:0] s, input logic [2:0] lvl);
    logic [MEM_AW-SECT_AW:0] span;
    span = '0;
    if (lvl == 3'h0) begin
      prot_hit = 1'b0;
    end else if (lvl == 3'h7) begin
      prot_hit = 1'b1;
    end else begin
      span = (MEM_AW-SECT_AW+1)'(NSECT >> (7 - int'(lvl)));
      prot_hit = ({1'b0, s} >= ((MEM_AW-SECT_AW+1)'(NSECT) - span));
    end
  endfunction

  // ****************************************
  // link domain: command capture
  // ****************************************
  sfrp_lst_t          st_r;
  sfrp_kind_t         kind_r;
  logic               act_r;
  logic [4:0]         cnt_r;
  logic [7:0]         sh_r;
  logic [MEM_AW-1:0]  addr_r;
  logic [7:0]         col_r;
  logic [7:0]         last_r;
  logic               got_r;
  logic               extra_r;
  logic               busy_l1_r;
  logic               busy_l2_r;
  logic               busy_r;

  sfrp_lst_t          cur_st;
  logic [4:0]         cur_cnt;
  logic               dual_in;
  logic [4:0]         cnt_nxt;
  logic [7:0]         sh_nxt;
  logic [MEM_AW-1:0]  addr_nxt;
  sfrp_kind_t         op_kind;

  // frame ends asynchronously on its own select, the link clock may stop afterwards
  always_ff @(posedge I_SCLK or negedge I_RSTN or posedge I_SELECT_N) begin
    if (!I_RSTN || I_SELECT_N) begin
      act_r <= 1'b0;
    end else begin
      act_r <= 1'b1;
    end
  end

  always_ff @(posedge I_SCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      busy_l1_r <= 1'b0;
      busy_l2_r <= 1'b0;
    end else begin
      busy_l1_r <= busy_r;
      busy_l2_r <= busy_l1_r;
    end
  end

  always_comb begin
    cur_st   = act_r ? st_r : L_CMD;
    cur_cnt  = act_r ? cnt_r : 5'h00;
    dual_in  = (cur_st == L_PDATA) && (kind_r == K_DPROG); // see RQ20
    cnt_nxt  = cur_cnt + (dual_in ? 5'h02 : 5'h01);
    sh_nxt   = dual_in ? {sh_r[5:0], I_IO_LINE_1, I_IO_LINE_0} : {sh_r[6:0], I_IO_LINE_0}; // see RQ23
    addr_nxt = {addr_r[MEM_AW-2:0], I_IO_LINE_0}; // see RQ24
    op_kind  = kind_of(sh_nxt);
  end

  always_ff @(posedge I_SCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st_r    <= L_IGNORE;
      kind_r  <= K_NONE;
      cnt_r   <= 5'h00;
      sh_r    <= 8'h00;
      addr_r  <= '0;
      col_r   <= 8'h00;
      last_r  <= 8'h00;
      got_r   <= 1'b0;
      extra_r <= 1'b0;
    end else begin
      sh_r    <= sh_nxt;
      cnt_r   <= cnt_nxt;
      if (!act_r) begin
        got_r   <= 1'b0;
        kind_r  <= K_NONE;
        extra_r <= 1'b0;
      end
      case (cur_st)
        L_CMD: begin
          st_r <= L_CMD;
          if (cnt_nxt == CMD_BITS) begin
            cnt_r  <= 5'h00;
            kind_r <= busy_l2_r ? K_NONE : op_kind;
            if (busy_l2_r || op_kind == K_NONE || op_kind == K_WREN || op_kind == K_WRDI) begin
              st_r <= L_IGNORE; // see RQ4
            end else begin
              st_r <= L_ADDR;
            end
          end
        end
        L_ADDR: begin
          addr_r <= addr_nxt; // see RQ1
          if (cnt_nxt == ADDR_BITS) begin
            cnt_r <= 5'h00;
            col_r <= addr_nxt[7:0];
            case (kind_r)
              K_LOCK:                    st_r <= L_RDATA; // see RQ7
              K_PROG, K_DPROG, K_LOCKWR: st_r <= L_PDATA; // see RQ13
              default:                   st_r <= L_DUMMY; // see RQ5
            endcase
          end
        end
        L_DUMMY: begin
          if (cnt_nxt == DUMMY_BITS) begin
            cnt_r <= 5'h00;
            st_r  <= L_RDATA; // see RQ10
          end
        end
        L_PDATA: begin
          if (cnt_nxt == BYTE_BITS) begin
            cnt_r  <= 5'h00;
            got_r  <= 1'b1;
            last_r <= sh_nxt;
            col_r  <= col_r + 8'h01; // see RQ14
          end
        end
        L_IGNORE: begin
          extra_r <= 1'b1;
        end
        default: begin
          st_r <= st_r;
        end
      endcase
    end
  end

  // page buffer: later bytes overwrite earlier ones at the same column
  always_ff @(posedge I_SCLK) begin
    if (act_r && cur_st == L_PDATA && cnt_nxt == BYTE_BITS) begin
      pbuf[col_r] <= sh_nxt; // see RQ15
    end
  end

  always_ff @(posedge I_SCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pmask_r <= '0;
    end else if (cur_st == L_CMD && cnt_nxt == CMD_BITS && !busy_l2_r) begin
      // cleared at decode only, a running cycle keeps its mask
      pmask_r <= '0;
    end else if (cur_st == L_PDATA && cnt_nxt == BYTE_BITS) begin
      pmask_r[col_r] <= 1'b1; // see RQ15
    end
  end

  // ****************************************
  // link domain: data output
  // ****************************************
  logic               drive_r;
  logic [2:0]         ocnt_r;
  logic [7:0]         osh_r;
  logic [MEM_AW-1:0]  raddr_r;
  logic               first_r;
  logic               o0_r;
  logic               o1_r;

  logic               rd_on;
  logic               dual_out;
  logic [MEM_AW-1:0]  cur_ra;
  logic [MEM_AW-1:0]  ra_nxt;
  logic [7:0]         ld_byte;
  logic [7:0]         cur_byte;
  logic [2:0]         ocnt_nxt;

  always_comb begin
    rd_on    = act_r && (st_r == L_RDATA);
    dual_out = (kind_r == K_DUAL);
    cur_ra   = first_r ? addr_r : raddr_r;
    ld_byte  = ERASED_BYTE;
    ra_nxt   = cur_ra + MEM_AW'(1); // see RQ2, RQ6
    case (kind_r)
      K_LOCK: begin
        ld_byte = 8'h00; // see RQ22
        ld_byte[LOCK_WL_BIT]  = lock_wl_r[sect_of(cur_ra)];
        ld_byte[LOCK_FRZ_BIT] = lock_frz_r[sect_of(cur_ra)];
        ra_nxt  = cur_ra;
      end
      K_OTP: begin
        ld_byte = ERASED_BYTE;
        ra_nxt  = '0;
        // no rollover: the index sticks on the last byte
        ra_nxt[6:0] = (cur_ra[6:0] >= OTP_LAST_IDX) ? OTP_LAST_IDX : cur_ra[6:0] + 7'h01; // see RQ11
      end
      default: begin
        ld_byte = mem[cur_ra];
      end
    endcase
    cur_byte = (ocnt_r == 3'h0) ? ld_byte : osh_r;
    ocnt_nxt = ocnt_r + (dual_out ? 3'h2 : 3'h1);
  end

  always_ff @(negedge I_SCLK or negedge I_RSTN or posedge I_SELECT_N) begin
    if (!I_RSTN || I_SELECT_N) begin
      drive_r <= 1'b0; // see RQ3
      ocnt_r  <= 3'h0;
      first_r <= 1'b1;
    end else if (!rd_on) begin
      drive_r <= 1'b0;
      ocnt_r  <= 3'h0;
      first_r <= 1'b1;
    end else begin
      drive_r <= 1'b1;
      first_r <= 1'b0;
      ocnt_r  <= ocnt_nxt;
    end
  end

  always_ff @(negedge I_SCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      osh_r   <= 8'h00;
      raddr_r <= '0;
      o0_r    <= 1'b0;
      o1_r    <= 1'b0;
    end else if (rd_on) begin
      o1_r  <= cur_byte[7]; // see RQ1, RQ23
      o0_r  <= cur_byte[6]; // see RQ5
      osh_r <= dual_out ? {cur_byte[5:0], 2'b00} : {cur_byte[6:0], 1'b0};
      if (ocnt_r == 3'h0) begin
        raddr_r <= cur_ra;
      end
      // byte done: advance for the next load
      if (ocnt_nxt == 3'h0) begin
        raddr_r <= ra_nxt; // see RQ2, RQ6, RQ10
      end
    end
  end

  // select gates the enables directly so release needs no clock edge
  assign O_IO_LINE_1      = o1_r;
  assign O_IO_LINE_0      = o0_r;
  assign O_IO_LINE_1_OE_N = I_SELECT_N | ~drive_r; // see RQ3
  assign O_IO_LINE_0_OE_N = I_SELECT_N | ~(drive_r & dual_out); // see RQ5

  // ****************************************
  // system domain: frame end and program cycle
  // ****************************************
  logic               sel_s1_r;
  logic               sel_s2_r;
  logic               sel_s3_r;
  logic [2:0]         prot_s1_r;
  logic [2:0]         prot_s2_r;
  logic               wel_r;
  sfrp_cst_t          cst_r;
  logic [PG_W-1:0]    page_r;
  logic [PAGE_AW:0]   wcol_r;
  logic [TMR_W-1:0]   tmr_r;

  logic               frame_end;
  logic               link_ok;
  logic [MEM_AW-SECT_AW-1:0] tsect;

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      sel_s1_r  <= 1'b1;
      sel_s2_r  <= 1'b1;
      sel_s3_r  <= 1'b1;
      prot_s1_r <= 3'h0;
      prot_s2_r <= 3'h0;
    end else begin
      sel_s1_r  <= I_SELECT_N;
      sel_s2_r  <= sel_s1_r;
      sel_s3_r  <= sel_s2_r;
      prot_s1_r <= {I_PROTECT_LEVEL_BIT2, I_PROTECT_LEVEL_BIT1, I_PROTECT_LEVEL_BIT0};
      prot_s2_r <= prot_s1_r;
    end
  end

  // link registers are quiet once select is high, so they are read as static words
  always_comb begin
    frame_end = sel_s2_r & ~sel_s3_r;
    link_ok   = ((st_r == L_PDATA) && (cnt_r == 5'h00) && got_r) ||
                ((st_r == L_IGNORE) && !extra_r && (kind_r == K_WREN || kind_r == K_WRDI)); // see RQ16
    tsect     = sect_of(addr_r);
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      wel_r      <= WEL_RESET;
      cst_r      <= C_IDLE;
      page_r     <= '0;
      wcol_r     <= '0;
      tmr_r      <= '0;
      lock_wl_r  <= {NSECT{LOCK_RESET}};
      lock_frz_r <= {NSECT{LOCK_RESET}};
    end else begin
      case (cst_r)
        C_IDLE: begin
          if (frame_end && link_ok) begin
            case (kind_r)
              K_WREN: wel_r <= 1'b1;
              K_WRDI: wel_r <= 1'b0;
              K_LOCKWR: begin
                if (wel_r && !lock_frz_r[tsect]) begin
                  lock_wl_r[tsect]  <= last_r[LOCK_WL_BIT]; // see RQ8
                  lock_frz_r[tsect] <= last_r[LOCK_FRZ_BIT]; // see RQ8
                end
                wel_r <= 1'b0;
              end
              K_PROG, K_DPROG: begin
                if (wel_r && !prot_hit(tsect, prot_s2_r) && !lock_wl_r[tsect]) begin // see RQ12, RQ19, RQ9
                  page_r <= addr_r[MEM_AW-1:PAGE_AW];
                  wcol_r <= '0;
                  tmr_r  <= '0;
                  wel_r  <= 1'b0; // see RQ17
                  cst_r  <= C_WRITE;
                end
              end
              default: wel_r <= wel_r;
            endcase
          end
        end
        C_WRITE: begin
          tmr_r  <= tmr_r + TMR_W'(1);
          wcol_r <= wcol_r + (PAGE_AW+1)'(1);
          if (wcol_r == (PAGE_AW+1)'(PAGE_N - 1)) begin
            cst_r <= C_WAIT;
          end
        end
        C_WAIT: begin
          tmr_r <= tmr_r + TMR_W'(1);
          // busy flop trails the state by one clock
          if (tmr_r >= TMR_W'(PROG_CYCLES - 2)) begin
            cst_r <= C_IDLE; // see RQ17
          end
        end
        default: begin
          cst_r <= C_IDLE;
        end
      endcase
    end
  end

  // array update: only masked columns, and bits can only fall
  always_ff @(posedge I_CLK) begin
    if (cst_r == C_WRITE && pmask_r[wcol_r[PAGE_AW-1:0]]) begin
      mem[{page_r, wcol_r[PAGE_AW-1:0]}] <= mem[{page_r, wcol_r[PAGE_AW-1:0]}] & pbuf[wcol_r[PAGE_AW-1:0]]; // see RQ18
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (cst_r != C_IDLE) || (frame_end && link_ok && (kind_r == K_PROG || kind_r == K_DPROG) &&
                wel_r && !prot_hit(tsect, prot_s2_r) && !lock_wl_r[tsect]); // see RQ17
    end
  end

  assign O_BUSY_FLAG        = busy_r;
  assign O_WRITE_LATCH_FLAG = wel_r;

endmodule

// ==== bench/sfrp_core_asserts.sv ====
// concurrent checks on the serial flash command engine ports
// assumes sfrp_core ports as declared; link clock unrelated to system clock
`timescale 1ns/1ns
module sfrp_core_asserts #(
  parameter int PROG_CYCLES = 300
) (
  // system
  input wire logic I_CLK, I_RSTN,
  // link
  input wire logic I_SCLK, I_SELECT_N, I_IO_LINE_0, I_IO_LINE_1,
  input wire logic O_IO_LINE_0, O_IO_LINE_0_OE_N, O_IO_LINE_1, O_IO_LINE_1_OE_N,
  // straps and status
  input wire logic I_PROTECT_LEVEL_BIT2, I_PROTECT_LEVEL_BIT1, I_PROTECT_LEVEL_BIT0,
  input wire logic O_BUSY_FLAG, O_WRITE_LATCH_FLAG
);
  int         busy_cnt_r;
  logic [5:0] rise_cnt_r = 6'h00;
  // ****
  // helpers
  // ****
  // busy length in system clocks; a long count cannot be unrolled
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) busy_cnt_r <= 0;
    else busy_cnt_r <= O_BUSY_FLAG ? busy_cnt_r + 1 : 0;
  end
  // rises seen in this frame, saturating
  always_ff @(posedge I_SCLK or posedge I_SELECT_N) begin
    if (I_SELECT_N) rise_cnt_r <= 6'h00;
    else if (rise_cnt_r != 6'h3F) rise_cnt_r <= rise_cnt_r + 6'h01;
  end
  // ****
  // assertions
  // ****
  a_oe_off_idle: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    I_SELECT_N |-> O_IO_LINE_0_OE_N && O_IO_LINE_1_OE_N) else $error("line driven while unselected");
  a_busy_quiet: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    O_BUSY_FLAG |-> O_IO_LINE_0_OE_N && O_IO_LINE_1_OE_N) else $error("read answered while busy");
  a_dual_pair: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    !O_IO_LINE_0_OE_N |-> !O_IO_LINE_1_OE_N) else $error("line 0 driven alone");
  a_header_done: assert property (@(posedge I_SCLK) disable iff (!I_RSTN)
    !O_IO_LINE_1_OE_N |-> rise_cnt_r >= 6'h20) else $error("data before header end");
  a_busy_len: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    $fell(O_BUSY_FLAG) |-> busy_cnt_r == PROG_CYCLES) else $error("busy length wrong");
  a_busy_cap: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    busy_cnt_r <= PROG_CYCLES) else $error("busy too long");
  a_busy_on_sel: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    $rose(O_BUSY_FLAG) |-> I_SELECT_N) else $error("cycle started inside frame");
  a_busy_needs_en: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    $rose(O_BUSY_FLAG) |-> $past(O_WRITE_LATCH_FLAG) || $past(O_WRITE_LATCH_FLAG, 2)
      || $past(O_WRITE_LATCH_FLAG, 3)) else $error("cycle without latch");
  a_latch_clear: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    $rose(O_BUSY_FLAG) |-> ##[0:4] !O_WRITE_LATCH_FLAG) else $error("latch not cleared");
  a_latch_idle: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    !$stable(O_WRITE_LATCH_FLAG) |-> I_SELECT_N) else $error("latch moved inside frame");
  c_prog: cover property (@(posedge I_CLK) $rose(O_BUSY_FLAG));
  c_dual: cover property (@(posedge I_CLK) !O_IO_LINE_0_OE_N);
  c_read: cover property (@(posedge I_CLK) $fell(O_IO_LINE_1_OE_N));
endmodule
bind sfrp_core sfrp_core_asserts #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.I_CLK(I_CLK), .I_RSTN(I_RSTN),
  .I_SCLK(I_SCLK), .I_SELECT_N(I_SELECT_N), .I_IO_LINE_0(I_IO_LINE_0), .I_IO_LINE_1(I_IO_LINE_1),
  .O_IO_LINE_0(O_IO_LINE_0), .O_IO_LINE_0_OE_N(O_IO_LINE_0_OE_N), .O_IO_LINE_1(O_IO_LINE_1),
  .O_IO_LINE_1_OE_N(O_IO_LINE_1_OE_N), .I_PROTECT_LEVEL_BIT2(I_PROTECT_LEVEL_BIT2),
  .I_PROTECT_LEVEL_BIT1(I_PROTECT_LEVEL_BIT1), .I_PROTECT_LEVEL_BIT0(I_PROTECT_LEVEL_BIT0),
  .O_BUSY_FLAG(O_BUSY_FLAG), .O_WRITE_LATCH_FLAG(O_WRITE_LATCH_FLAG));

// ==== bench/sfrp_host.sv ====
// host serial controller model: makes select, link clock and line levels
// assumes the bench calls frame() and resolves nothing itself
`timescale 1ns/1ns
module sfrp_host (
  // device side
  input  wire logic i_d0, i_oe0_n, i_d1, i_oe1_n,
  // link
  output logic      o_sclk, o_sel_n,
  output wire logic o_l0, o_l1
);
  logic       h0 = 1'b0;
  logic       h1 = 1'b0;
  logic [7:0] rx;
  event       got;
  initial begin
    o_sclk = 1'b0;
    o_sel_n = 1'b1;
  end
  assign o_l0 = !i_oe0_n ? i_d0 : h0;
  assign o_l1 = !i_oe1_n ? i_d1 : h1;
  // ****
  // bit level
  // ****
  // clock stands low outside frames; lines change after the fall
  task automatic tick(input logic b1, input logic b0);
    h1 = b1;
    h0 = b0;
    #15 o_sclk = 1'b1;
    #15 o_sclk = 1'b0;
  endtask
  task automatic send(input logic [7:0] b, input bit two);
    for (int i = 7; i >= 0; i -= two ? 2 : 1) tick(two ? b[i] : ~h1, b[two ? i - 1 : i]);
  endtask
  task automatic recv(input bit two);
    logic [7:0] b;
    bit         drv;
    h0 = ~o_l0;
    h1 = ~o_l1;
    drv = 1'b0;
    for (int i = 7; i >= 0; i -= two ? 2 : 1) begin
      #15 o_sclk = 1'b1;
      b[i] = o_l1;
      if (two) b[i - 1] = o_l0;
      drv |= !i_oe1_n;
      #15 o_sclk = 1'b0;
    end
    rx = b;
    if (drv) ->got;
  endtask
  // ****
  // frame: select low throughout, whole bytes unless extra bits asked
  // ****
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int nhdr, input int nrd,
                       input bit two, input logic [7:0] wd[$], input int extra);
    logic [31:0] h;
    h = {a, 8'h00};
    o_sel_n = 1'b0;
    #15;
    send(op, 1'b0);
    for (int k = 0; k < nhdr; k++) send(h[31 - 8 * k -: 8], 1'b0);
    foreach (wd[k]) send(wd[k], two);
    for (int k = 0; k < extra; k++) tick(~h1, 1'b1);
    for (int k = 0; k < nrd; k++) recv(two);
    #15 o_sel_n = 1'b1;
    #700;
  endtask
endmodule

// ==== bench/sfrp_core_bench.sv ====
// self-checking bench for the serial flash command engine
// assumes sfrp_host as link partner; 4 KiB array, 1 KiB sectors
`timescale 1ns/1ns
module sfrp_core_bench;
  import sfrp_pkg::*;
  localparam int PC = 300;
  logic        I_CLK = 1'b0;
  logic        I_RSTN = 1'b0;
  logic [2:0]  prot = 3'h0;
  wire         sclk, sel_n, l0, l1, o0, e0_n, o1, e1_n, busy, write_latch_flag;
  int          err_total = 0;
  int          tests_run = 0;
  int          cyc = 0;
  logic [31:0] lfsr = 32'hB7093C0E;
  logic [7:0]  mem [0:4095];
  logic [7:0]  expq[$], dq[$], nd[$];
  always #50 I_CLK = ~I_CLK;
  sfrp_core #(.MEM_AW(12), .SECT_AW(10), .PROG_CYCLES(PC)) i_sfrp_core (
    .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_SCLK(sclk), .I_SELECT_N(sel_n), .I_IO_LINE_0(l0),
    .I_IO_LINE_1(l1), .O_IO_LINE_0(o0), .O_IO_LINE_0_OE_N(e0_n), .O_IO_LINE_1(o1),
    .O_IO_LINE_1_OE_N(e1_n), .I_PROTECT_LEVEL_BIT2(prot[2]), .I_PROTECT_LEVEL_BIT1(prot[1]),
    .I_PROTECT_LEVEL_BIT0(prot[0]), .O_BUSY_FLAG(busy), .O_WRITE_LATCH_FLAG(write_latch_flag));
  sfrp_host i_sfrp_host (.i_d0(o0), .i_oe0_n(e0_n), .i_d1(o1), .i_oe1_n(e1_n),
    .o_sclk(sclk), .o_sel_n(sel_n), .o_l0(l0), .o_l1(l1));
  // ****
  // helpers
  // ****
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(i_sfrp_host.got) begin
    if (expq.size() == 0) chk("unexpected read", 8'h01, 8'h00);
    else chk("read byte", i_sfrp_host.rx, expq.pop_front());
  end
  always @(posedge I_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  // ****
  // operations
  // ****
  task automatic wren();
    i_sfrp_host.frame(OP_WR_EN, 24'h0, 0, 0, 1'b0, nd, 0);
    chk("latch set", {7'h0, write_latch_flag}, 8'h01);
  endtask
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input int n);
    for (int k = 0; k < n; k++) expq.push_back(op == OP_OTP_RD ? ERASED_BYTE : mem[(a[11:0] + k) % 4096]);
    i_sfrp_host.frame(op, a, 4, n, op == OP_DUAL_RD, nd, 0);
    chk("bytes left", 8'(expq.size()), 8'h00);
    $display("read %h at %h done", op, a);
  endtask
  task automatic lock(input logic [23:0] a, input logic [7:0] wv, input logic [7:0] rv);
    wren();
    dq = {wv};
    i_sfrp_host.frame(OP_LOCK_WR, a, 3, 0, 1'b0, dq, 0);
    expq.push_back(rv);
    i_sfrp_host.frame(OP_LOCK_RD, a ^ 24'h0000FF, 3, 1, 1'b0, nd, 0);
    $display("lock %h at %h done", wv, a);
  endtask
  task automatic prog(input logic [7:0] op, input logic [23:0] a, input int n,
                      input bit ok, input int extra, input bit wen);
    logic [7:0] pg [0:255];
    bit         hit [0:255];
    dq = {};
    hit = '{default: 1'b0};
    if (wen) wren();
    for (int k = 0; k < n; k++) begin
      lfsr = nx(lfsr);
      dq.push_back(lfsr[7:0]);
      pg[(a[7:0] + k) % 256] = lfsr[7:0];
      hit[(a[7:0] + k) % 256] = 1'b1;
    end
    i_sfrp_host.frame(op, a, 3, 0, op == OP_DUAL_PROG, dq, extra);
    chk("busy", {7'h0, busy}, {7'h0, ok});
    chk("latch", {7'h0, write_latch_flag}, {7'h0, wen & !ok});
    if (ok) begin
      i_sfrp_host.frame(OP_FAST_RD, a, 4, 1, 1'b0, nd, 0);
      chk("busy kept", {7'h0, busy}, 8'h01);
      for (int k = 0; k < 256; k++) if (hit[k]) mem[{a[11:8], k[7:0]}] &= pg[k];
    end
    for (int k = 0; k < PC + 20 && busy; k++) @(posedge I_CLK);
    chk("busy end", {7'h0, busy}, 8'h00);
    $display("program %h at %h done", op, a);
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    for (int k = 0; k < 4096; k++) mem[k] = ERASED_BYTE;
    repeat (12) @(posedge I_CLK);
    #5 I_RSTN = 1'b1;
    repeat (4) @(posedge I_CLK);
    chk("reset busy", {7'h0, busy}, 8'h00);
    chk("reset latch", {7'h0, write_latch_flag}, {7'h0, WEL_RESET});
    prog(OP_PROG, 24'h0F0, 2, 1'b0, 0, 1'b0);
    prog(OP_PROG, 24'h0FE, 4, 1'b1, 0, 1'b1);
    rd(OP_FAST_RD, 24'h0FC, 6);
    rd(OP_FAST_RD, 24'hFFF, 2);
    rd(OP_DUAL_RD, 24'h0FF, 3);
    prog(OP_DUAL_PROG, 24'h200, 3, 1'b1, 0, 1'b1);
    prog(OP_DUAL_PROG, 24'h201, 3, 1'b1, 0, 1'b1);
    rd(OP_DUAL_RD, 24'h200, 5);
    prog(OP_PROG, 24'h300, 258, 1'b1, 0, 1'b1);
    rd(OP_FAST_RD, 24'h2FF, 3);
    prog(OP_PROG, 24'h210, 1, 1'b0, 3, 1'b1);
    @(posedge I_CLK) #5 prot = 3'h7;
    repeat (4) @(posedge I_CLK);
    prog(OP_DUAL_PROG, 24'h600, 1, 1'b0, 0, 1'b1);
    @(posedge I_CLK) #5 prot = 3'h0;
    repeat (4) @(posedge I_CLK);
    lock(24'h5AA, 8'h01, 8'h01);
    prog(OP_PROG, 24'h410, 1, 1'b0, 0, 1'b1);
    lock(24'h400, 8'h03, 8'h03);
    lock(24'h400, 8'h00, 8'h03);
    lock(24'h000, 8'h00, 8'h00);
    rd(OP_OTP_RD, 24'h000, 66);
    complete_run();
  end
endmodule
